/* File: logic/tff_regs.vh */
// tff_regs.vh: register map, field positions and reset values of the timer flip-flop control block.
// assumes byte-wide software registers at the printed byte offsets, reached over a plain strobe port.
`ifndef TFF_REGS_VH
`define TFF_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define TFF_ADDR_W 9
`define TFF_OFS_CMP0 9'h100
`define TFF_OFS_CMP1 9'h103
`define TFF_OFS_CMP2 9'h10a
`define TFF_OFS_CMP3 9'h10b
`define TFF_OFS_P3CTL 9'h10d
`define TFF_OFS_CMP4 9'h112
`define TFF_OFS_CMP5 9'h113
`define TFF_OFS_P5CTL 9'h115
`define TFF_OFS_MODE 9'h116
`define TFF_OFS_RUN 9'h117
`define TFF_OFS_STAT 9'h118

// ****************************************
// control register fields
// ****************************************
`define TFF_FLD_SRC 0
`define TFF_FLD_INV_EN 1
`define TFF_FLD_CMD_LO 2
`define TFF_FLD_CMD_HI 3
`define TFF_CTL_UPPER 4'hf
`define TFF_CTL_RESET 4'hc

// ****************************************
// command codes and pair modes
// ****************************************
`define TFF_CMD_INVERT 2'h0
`define TFF_CMD_SET 2'h1
`define TFF_CMD_CLEAR 2'h2
`define TFF_MODE_8BIT 2'h0
`define TFF_CMP_RESET 8'h00

`endif

/* File: logic/tff_timer.v */
// tff_timer.v: one 8-bit up-counter with a write-only compare value and a match pulse.
// assumes software stops the counter before it rewrites the compare value.
`timescale 1ns/1ns
`default_nettype none
`include "tff_regs.vh"

module tff_timer #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire mclk,
    input wire nrst,
    // control
    input wire run,
    input wire cmp_we,
    input wire [WIDTH-1:0] cmp_wdata,
    // status
    output reg [WIDTH-1:0] count_r,
    output reg match_r
);

    reg [WIDTH-1:0] cmp_r;
    wire hit;

    // ****************************************
    // compare and count
    // ****************************************
    assign hit = run && (count_r == cmp_r);

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmp_r <= `TFF_CMP_RESET;
            count_r <= `TFF_CMP_RESET;
            match_r <= 1'b0;
        end else begin
            if (cmp_we) begin
                cmp_r <= cmp_wdata;
            end
            match_r <= hit;
            if (!run || hit) begin
                // a stopped counter sits at zero, a match restarts the interval
                count_r <= {WIDTH{1'b0}};
            end else begin
                count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // tff_timer

`default_nettype wire

/* File: logic/tff_ctrl.v */
// tff_ctrl.v: six 8-bit interval timers, their compare registers and the output flip-flops of pairs three and five.
// assumes a single-clock software port with read data one cycle after the read strobe.
//
// Operation
// - pair-three command 00 toggle, 01 set, 10 clear
// - pair-five command decodes the same way
// - pair-three source 0 timer two, 1 timer three
// - pair-five source 0 timer four, 1 timer five
// - auto invert only when enabled, in 8-bit mode
// - control registers read ones in bits 7..4
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tff_regs.vh"

module tff_ctrl #(
    parameter NTIMER = 6,
    parameter DATA_W = 8
) (
    // clock and reset
    input wire mclk,
    input wire nrst,
    // software register port
    input wire [`TFF_ADDR_W-1:0] addr,
    input wire [DATA_W-1:0] wdata,
    input wire wr,
    input wire rd,
    output reg [DATA_W-1:0] rdata_r,
    // timer events and outputs
    output wire [NTIMER-1:0] timer_match,
    output reg pair3_output_flipflop,
    output reg pair5_output_flipflop
);

    // ****************************************
    // software-visible state
    // ****************************************
    reg [3:0] pair3_ctl_r;
    reg [3:0] pair5_ctl_r;
    reg [3:0] pair_mode_r;
    reg [NTIMER-1:0] run_r;
    reg [DATA_W-1:0] rdata_nxt;
    reg [NTIMER-1:0] cmp_we;
    wire [NTIMER-1:0] match;
    wire [DATA_W*NTIMER-1:0] counts;
    wire p3_ctl_wr;
    wire p5_ctl_wr;
    wire p3_auto;
    wire p5_auto;

    assign p3_ctl_wr = wr && (addr == `TFF_OFS_P3CTL);
    assign p5_ctl_wr = wr && (addr == `TFF_OFS_P5CTL);
    assign timer_match = match;

    always @* begin
        cmp_we = {NTIMER{1'b0}};
        if (wr) begin
            case (addr)
                `TFF_OFS_CMP0: cmp_we[0] = 1'b1;
                `TFF_OFS_CMP1: cmp_we[1] = 1'b1;
                `TFF_OFS_CMP2: cmp_we[2] = 1'b1;
                `TFF_OFS_CMP3: cmp_we[3] = 1'b1;
                `TFF_OFS_CMP4: cmp_we[4] = 1'b1;
                `TFF_OFS_CMP5: cmp_we[5] = 1'b1;
                default: cmp_we = {NTIMER{1'b0}};
            endcase
        end
    end

    // ****************************************
    // timers
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NTIMER; gi = gi + 1) begin : g_tmr
            tff_timer #(
                .WIDTH(DATA_W)
            ) u_tmr (
                .mclk(mclk),
                .nrst(nrst),
                .run(run_r[gi]),
                .cmp_we(cmp_we[gi]),
                .cmp_wdata(wdata),
                .count_r(counts[gi*DATA_W +: DATA_W]),
                .match_r(match[gi])
            );
        end
    endgenerate

    // ****************************************
    // automatic inversion sources
    // ****************************************
    // pair mode bits [1:0] govern timers two/three, [3:2] timers four/five
    assign p3_auto = pair3_ctl_r[`TFF_FLD_INV_EN] && (pair_mode_r[1:0] == `TFF_MODE_8BIT) &&
        (pair3_ctl_r[`TFF_FLD_SRC] ? match[3] : match[2]);
    assign p5_auto = pair5_ctl_r[`TFF_FLD_INV_EN] && (pair_mode_r[3:2] == `TFF_MODE_8BIT) &&
        (pair5_ctl_r[`TFF_FLD_SRC] ? match[5] : match[4]);

    // ****************************************
    // register writes and flip-flops
    // ****************************************
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pair3_ctl_r <= `TFF_CTL_RESET;
            pair5_ctl_r <= `TFF_CTL_RESET;
            pair_mode_r <= 4'h0;
            run_r <= {NTIMER{1'b0}};
            pair3_output_flipflop <= 1'b0;
            pair5_output_flipflop <= 1'b0;
        end else begin
            if (wr && addr == `TFF_OFS_MODE) begin
                pair_mode_r <= wdata[3:0];
            end
            if (wr && addr == `TFF_OFS_RUN) begin
                run_r <= wdata[NTIMER-1:0];
            end
            // a software command takes priority over a match in the same cycle
            if (p3_ctl_wr) begin
                pair3_ctl_r <= wdata[3:0];
                case (wdata[`TFF_FLD_CMD_HI:`TFF_FLD_CMD_LO])
                    `TFF_CMD_INVERT: pair3_output_flipflop <= ~pair3_output_flipflop;
                    `TFF_CMD_SET: pair3_output_flipflop <= 1'b1;
                    `TFF_CMD_CLEAR: pair3_output_flipflop <= 1'b0;
                    default: pair3_output_flipflop <= pair3_output_flipflop ^ p3_auto;
                endcase
            end else if (p3_auto) begin
                pair3_output_flipflop <= ~pair3_output_flipflop;
            end
            if (p5_ctl_wr) begin
                pair5_ctl_r <= wdata[3:0];
                case (wdata[`TFF_FLD_CMD_HI:`TFF_FLD_CMD_LO])
                    `TFF_CMD_INVERT: pair5_output_flipflop <= ~pair5_output_flipflop;
                    `TFF_CMD_SET: pair5_output_flipflop <= 1'b1;
                    `TFF_CMD_CLEAR: pair5_output_flipflop <= 1'b0;
                    default: pair5_output_flipflop <= pair5_output_flipflop ^ p5_auto;
                endcase
            end else if (p5_auto) begin
                pair5_output_flipflop <= ~pair5_output_flipflop;
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // compare registers are write-only and read as zero
    always @* begin
        rdata_nxt = {DATA_W{1'b0}};
        case (addr)
            `TFF_OFS_P3CTL: rdata_nxt = {`TFF_CTL_UPPER, pair3_ctl_r};
            `TFF_OFS_P5CTL: rdata_nxt = {`TFF_CTL_UPPER, pair5_ctl_r};
            `TFF_OFS_MODE: rdata_nxt = {4'h0, pair_mode_r};
            `TFF_OFS_RUN: rdata_nxt = {{(DATA_W-NTIMER){1'b0}}, run_r};
            `TFF_OFS_STAT: rdata_nxt = {6'h00, pair5_output_flipflop, pair3_output_flipflop};
            default: rdata_nxt = {DATA_W{1'b0}};
        endcase
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= {DATA_W{1'b0}};
        end else if (rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= {DATA_W{1'b0}};
        end
    end

endmodule // tff_ctrl

`default_nettype wire

/* File: test/tff_ctrl_checker.sv */
// tff_ctrl_checker.sv: port-level properties of the timer flip-flop control block.
// assumes it is bound to tff_ctrl and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module tff_ctrl_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register port
    input wire logic [8:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata_r,
    // outputs
    input wire logic [5:0] timer_match,
    input wire logic pair3_output_flipflop,
    input wire logic pair5_output_flipflop
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire w3 = wr && addr == 9'h10d;
    wire w5 = wr && addr == 9'h115;
    a_p3_set: assert property (w3 && wdata[3:2] == 2'h1 |=> pair3_output_flipflop) else $error("p3 set");
    a_p3_clr: assert property (w3 && wdata[3:2] == 2'h2 |=> !pair3_output_flipflop) else $error("p3 clr");
    a_p3_tog: assert property (w3 && wdata[3:2] == 2'h0 |=> pair3_output_flipflop != $past(pair3_output_flipflop))
        else $error("p3 toggle");
    a_p5_set: assert property (w5 && wdata[3:2] == 2'h1 |=> pair5_output_flipflop) else $error("p5 set");
    a_p5_tog: assert property (w5 && wdata[3:2] == 2'h0 |=> pair5_output_flipflop != $past(pair5_output_flipflop))
        else $error("p5 toggle");
    a_ctl_upper: assert property (rd && (addr == 9'h10d || addr == 9'h115) |=> rdata_r[7:4] == 4'hf)
        else $error("ctl upper bits");
    a_p3_hold: assert property (!w3 && timer_match[3:2] == 2'h0 |=> $stable(pair3_output_flipflop))
        else $error("p3 spurious change");
    a_p5_hold: assert property (!w5 && timer_match[5:4] == 2'h0 |=> $stable(pair5_output_flipflop))
        else $error("p5 spurious change");
    c_auto3: cover property (timer_match[2] ##1 $changed(pair3_output_flipflop));
    c_auto5: cover property (timer_match[5] ##1 $changed(pair5_output_flipflop));
    c_rd: cover property (rd ##1 rdata_r == 8'hfc);
endmodule // tff_ctrl_checker
`default_nettype wire

/* File: test/tff_ctrl_bench.sv */
// tff_ctrl_bench.sv: self-checking bench for tff_ctrl, random commands plus timer-driven inversion.
// assumes the register port answers reads exactly one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module tff_ctrl_bench;
    logic mclk = 0, nrst = 0, wr = 0, rd = 0;
    logic [8:0] addr = 0;
    logic [7:0] wdata = 0, rdata_r, d;
    logic [5:0] timer_match;
    logic p3, p5, e3, e5, a, b;
    int miscompares = 0, check_count = 0, t3, t5, m2, m0, m1;
    tff_ctrl i_tff_ctrl (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r), .timer_match(timer_match), .pair3_output_flipflop(p3), .pair5_output_flipflop(p5));
    initial forever #25 mclk = ~mclk;
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrt(input logic [8:0] ad, input logic [7:0] dt);
        @(posedge mclk);
        addr <= ad;
        wdata <= dt;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [8:0] ad, input logic [7:0] e);
        @(posedge mclk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk("rdata", rdata_r, e);
    endtask
    function automatic logic nff(input logic f, input logic [1:0] c);
        nff = (c == 2'h0) ? ~f : (c == 2'h1) ? 1'b1 : (c == 2'h2) ? 1'b0 : f;
    endfunction
    // count flip-flop changes and timer-zero, timer-one and timer-two matches over n cycles
    task automatic win(input int n);
        {t3, t5, m2, m0, m1} = 0;
        repeat (n) begin
            a = p3;
            b = p5;
            @(posedge mclk);
            #1;
            t3 += int'(a != p3);
            t5 += int'(b != p5);
            m2 += int'(timer_match[2]);
            m0 += int'(timer_match[0]);
            m1 += int'(timer_match[1]);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hbc46bb0b));
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rdc(9'h10d, 8'hfc);
        rdc(9'h115, 8'hfc);
        rdc(9'h10a, 8'h00);
        rdc(9'h1ff, 8'h00);
        {e3, e5} = 2'b00;
        repeat (24) begin
            d = 8'($urandom);
            wrt(9'h10d, d);
            e3 = nff(e3, d[3:2]);
            chk("p3", {7'h0, p3}, {7'h0, e3});
            wrt(9'h115, ~d);
            e5 = nff(e5, ~d[3:2]);
            chk("p5", {7'h0, p5}, {7'h0, e5});
            rdc(9'h10d, {4'hf, d[3:0]});
        end
        rdc(9'h118, {6'h00, e5, e3});
        // compares written while every timer is stopped
        wrt(9'h10a, 8'h03);
        wrt(9'h10b, 8'h05);
        wrt(9'h112, 8'h03);
        wrt(9'h113, 8'h05);
        wrt(9'h100, 8'h01);
        wrt(9'h103, 8'h02);
        wrt(9'h117, 8'h3c);
        rdc(9'h10a, 8'h00);
        for (int s = 0; s < 2; s++) begin
            wrt(9'h10d, 8'h0e | 8'(s));
            wrt(9'h115, 8'h0e | 8'(s));
            repeat (2) @(posedge mclk);
            win(24);
            chk("m2", 8'(m2), 8'd6);
            chk("t3", 8'(t3), s ? 8'd4 : 8'd6);
            chk("t5", 8'(t5), s ? 8'd4 : 8'd6);
        end
        wrt(9'h10d, 8'h0d);
        wrt(9'h116, 8'h04);
        rdc(9'h116, 8'h04);
        rdc(9'h117, 8'h3c);
        wrt(9'h117, 8'h3f);
        repeat (2) @(posedge mclk);
        win(24);
        chk("m0", 8'(m0), 8'd12);
        chk("m1", 8'(m1), 8'd8);
        chk("t3off", 8'(t3), 8'd0);
        chk("t5mode", 8'(t5), 8'd0);
        conclude();
    end
endmodule // tff_ctrl_bench
bind tff_ctrl tff_ctrl_checker i_tff_ctrl_checker (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_r(rdata_r), .timer_match(timer_match),
    .pair3_output_flipflop(pair3_output_flipflop), .pair5_output_flipflop(pair5_output_flipflop));
`default_nettype wire
